// *** pkg/slot_pkg.sv ***
// package for the command-slot handshake block
// assumes one 100 MHz clock and controller words presented synchronously
package slot_pkg;
  localparam int NUM_SLOTS = 4;
  localparam int WORD_W = 16;
  localparam int GROUP_W = 4;
  // control/status group bit positions (bit 1 of the word is index 0)
  localparam int ERR_ACK_BIT = 0;
  localparam int SYNC_MODE_BIT = 1;
  localparam int TRIGGER_BIT = 2;
  localparam int ABORT_REQ_BIT = 3;
  localparam int CMD_ERR_BIT = 0;
  localparam int READ_ERR_BIT = 1;
  localparam int BUSY_BIT = 2;
  localparam int ABORT_BUSY_BIT = 3;
  // module control word bits
  localparam int MOD_RESET_BIT = 0;
  localparam int SHARED_EN_BIT = 6;
  localparam logic [15:0] MODULE_CTRL_MASK = 16'h0041;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] SIGNATURE = 8'h4B;
  localparam logic [15:0] ERR_BAD_EXEC = 16'h0001;
  localparam logic [3:0] BLOCK_OFS_ERROR = 4'h0;
  localparam logic [3:0] BLOCK_OFS_SIGNATURE = 4'h3;
  // time for one slot to abort
  localparam int ABORT_NS = 100;
  localparam int CLK_NS = 10;
  localparam int ABORT_CYCLES = (ABORT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] ABORT_CNT_INIT = 4'(ABORT_CYCLES);

  typedef struct packed {
    logic err_ack;
    logic sync_mode;
    logic trigger;
    logic abort_req;
  } slot_ctrl_t;

  typedef struct packed {
    logic cmd_err;
    logic read_err;
    logic busy;
    logic abort_busy;
  } slot_status_t;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

  typedef enum logic [5:0] {
    S_IDLE  = 6'b00_0001,
    S_FETCH = 6'b00_0010,
    S_EXEC  = 6'b00_0100,
    S_HOLD  = 6'b00_1000,
    S_ERROR = 6'b01_0000,
    S_ABORT = 6'b10_0000
  } slot_state_t;

  function automatic slot_ctrl_t ctrl_group(input logic [15:0] w, input int s);
    logic [3:0] g;
    g = w[s*GROUP_W +: GROUP_W];
    ctrl_group = '{err_ack: g[ERR_ACK_BIT], sync_mode: g[SYNC_MODE_BIT],
                   trigger: g[TRIGGER_BIT], abort_req: g[ABORT_REQ_BIT]};
  endfunction : ctrl_group
endpackage : slot_pkg

// *** logic/slot_engine.sv ***
// one independent command slot state machine
// assumes a shared block-memory port granted by the parent
`timescale 1ns/1ps
`default_nettype none
module slot_engine
  import slot_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire slot_ctrl_t   ctrl,
  input  wire logic [15:0]  pointer,
  input  wire logic         grant,
  input  wire logic [15:0]  rdata,
  input  wire logic         exec_fail,
  output var  mem_req_t     mem,
  output var  slot_status_t status
);
  slot_state_t  state_q;
  logic         coupled_q;
  logic [3:0]   abort_cnt_q;
  logic         ack_prev_q;

  always_ff @(posedge sys_clk) begin
    if (rst) ack_prev_q <= 1'b0;
    else ack_prev_q <= ctrl.err_ack;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q     <= S_IDLE;
      coupled_q   <= 1'b0;
      abort_cnt_q <= 4'h0;
      status      <= '0;
      mem         <= '0;
    end else begin
      mem.req <= 1'b0;
      if (ctrl.abort_req && state_q != S_ABORT && state_q != S_IDLE && state_q != S_ERROR) begin
        state_q           <= S_ABORT;
        status.abort_busy <= 1'b1;
        abort_cnt_q       <= ABORT_CNT_INIT;
      end else begin
        case (state_q)
          S_IDLE: begin
            if (ctrl.trigger) begin
              status.busy <= 1'b1;
              coupled_q   <= ctrl.sync_mode;
              if (pointer == WORD_ZERO) begin
                status.cmd_err  <= 1'b1;
                status.read_err <= 1'b1;
                state_q         <= S_ERROR;
              end else begin
                mem     <= '{req: 1'b1, wr: 1'b0, addr: pointer + 16'(BLOCK_OFS_SIGNATURE), wdata: WORD_ZERO};
                state_q <= S_FETCH;
              end
            end
          end
          S_FETCH: begin
            if (!grant) mem.req <= 1'b1;
            else begin
              if (rdata[15:8] != SIGNATURE) begin
                status.cmd_err  <= 1'b1;
                status.read_err <= 1'b1;
                state_q         <= S_ERROR;
              end else state_q <= S_EXEC;
            end
          end
          S_EXEC: begin
            if (exec_fail) begin
              status.cmd_err <= 1'b1;
              mem <= '{req: 1'b1, wr: 1'b1, addr: pointer + 16'(BLOCK_OFS_ERROR), wdata: ERR_BAD_EXEC};
              state_q <= S_ERROR;
            end else state_q <= S_HOLD;
          end
          S_HOLD: begin
            if (!coupled_q || !ctrl.trigger) begin
              status.busy <= 1'b0;
              state_q     <= S_IDLE;
            end
          end
          S_ERROR: begin
            if (mem.req && mem.wr && !grant) mem.req <= 1'b1;
            if (ctrl.err_ack && !ack_prev_q) begin
              status <= '0;
              state_q <= S_IDLE;
            end
          end
          S_ABORT: begin
            if (abort_cnt_q == 4'h1) begin
              status.abort_busy <= 1'b0;
              status.busy       <= 1'b0;
              state_q           <= S_IDLE;
            end
            abort_cnt_q <= abort_cnt_q - 4'h1;
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule : slot_engine
`default_nettype wire

// *** logic/slot_handshake.sv ***
// command-slot handshake top: four slots, status word, module reset request
// assumes controller words sampled on sys_clk; block memory answers same cycle as grant
`timescale 1ns/1ps
`default_nettype none
// How it works
// - reset only with reset bit and four aborts
// - control bit 7 shares data; others zero
// - four 4-bit groups, one per slot
// - slots run independently except for the shared memory port
// - group bits: ack, mode, trigger, abort
// - mode 0 uncoupled, 1 coupled
// - status bits: error, read error, busy, abort
// - busy from trigger until command done
// - failure sets error, writes code offset 0
// - bad block sets read and command error
// - zero pointer invalid, 16-bit address range
// - errors halt slot until acknowledged
// - acknowledge aborts and clears error flags
// - abort busy raised, dropped with busy
// - any slot combination triggers concurrently
// - coupled busy holds while trigger high
// - uncoupled re-runs while trigger stays set
// - signature high byte must be 4B
module slot_handshake
  import slot_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [15:0] module_control_word,
  input  wire logic [15:0] command_control_word,
  input  wire logic [15:0] slot1_block_pointer,
  input  wire logic [15:0] slot2_block_pointer,
  input  wire logic [15:0] slot3_block_pointer,
  input  wire logic [15:0] slot4_block_pointer,
  input  wire logic [15:0] mem_rdata,
  input  wire logic [3:0]  exec_fail,
  output logic [15:0]      command_status_word,
  output logic             mem_req,
  output logic             mem_wr,
  output logic [15:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  output logic             shared_data_enable,
  output logic             module_reset
);
  logic [15:0]  ptr [NUM_SLOTS];
  mem_req_t     slot_mem [NUM_SLOTS];
  slot_status_t slot_stat [NUM_SLOTS];
  logic [3:0]   grant;
  logic [3:0]   abort_all;

  assign ptr[0] = slot1_block_pointer;
  assign ptr[1] = slot2_block_pointer;
  assign ptr[2] = slot3_block_pointer;
  assign ptr[3] = slot4_block_pointer;

  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
    slot_engine u_slot (
      .sys_clk (sys_clk),
      .rst     (rst || module_reset),
      .ctrl    (ctrl_group(command_control_word, s)),
      .pointer (ptr[s]),
      .grant   (grant[s]),
      .rdata   (mem_rdata),
      .exec_fail (exec_fail[s]),
      .mem     (slot_mem[s]),
      .status  (slot_stat[s])
    );
    assign abort_all[s] = command_control_word[s*GROUP_W + ABORT_REQ_BIT];
  end

  // fixed-priority memory port arbiter
  always_comb begin
    grant = 4'h0;
    for (int s = 0; s < NUM_SLOTS; s++) begin
      if (slot_mem[s].req && grant == 4'h0) grant[s] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_req   <= 1'b0;
      mem_wr    <= 1'b0;
      mem_addr  <= WORD_ZERO;
      mem_wdata <= WORD_ZERO;
    end else begin
      mem_req <= 1'b0;
      for (int s = 0; s < NUM_SLOTS; s++) begin
        if (grant[s]) begin
          mem_req   <= 1'b1;
          mem_wr    <= slot_mem[s].wr;
          mem_addr  <= slot_mem[s].addr;
          mem_wdata <= slot_mem[s].wdata;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) command_status_word <= WORD_ZERO;
    else begin
      for (int s = 0; s < NUM_SLOTS; s++) begin
        command_status_word[s*GROUP_W + CMD_ERR_BIT]    <= slot_stat[s].cmd_err;
        command_status_word[s*GROUP_W + READ_ERR_BIT]   <= slot_stat[s].read_err;
        command_status_word[s*GROUP_W + BUSY_BIT]       <= slot_stat[s].busy;
        command_status_word[s*GROUP_W + ABORT_BUSY_BIT] <= slot_stat[s].abort_busy;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) shared_data_enable <= 1'b0;
    else shared_data_enable <= module_control_word[SHARED_EN_BIT];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) module_reset <= 1'b0;
    else module_reset <= module_control_word[MOD_RESET_BIT] && (&abort_all);
  end
endmodule : slot_handshake
`default_nettype wire

// *** dv/slot_handshake_properties.sv ***
// port checker for slot_handshake
// assumes one clock domain, bound below
`timescale 1ns/1ps
`default_nettype none
module slot_handshake_properties
  import slot_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [15:0] module_control_word,
  input wire logic [15:0] command_control_word,
  input wire logic [15:0] command_status_word,
  input wire logic        mem_req,
  input wire logic        mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic        module_reset
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic [15:0] c = command_control_word;
  wire logic [15:0] s = command_status_word;
  property p_mod_rst;
    module_reset == $past(module_control_word[0] && c[3] && c[7] && c[11] && c[15]);
  endproperty
  a_mod_rst: assert property (p_mod_rst) else $error("module reset wrong");
  property p_rst_clear;
    module_reset |-> ##2 (s == WORD_ZERO);
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("status kept");
  property p_busy_rise;
    $rose(s[2]) |-> $past(c[2], 2);
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy untriggered");
  property p_abort_len;
    $rose(s[3]) |-> (s[3] && s[2]) [*8];
  endproperty
  a_abort_len: assert property (p_abort_len) else $error("abort short");
  property p_abort_end;
    $fell(s[3]) |-> $fell(s[2]);
  endproperty
  a_abort_end: assert property (p_abort_end) else $error("busy not dropped");
  property p_err_pair;
    ((s >> 1) & ~s & 16'h1111) == 16'h0000;
  endproperty
  a_err_pair: assert property (p_err_pair) else $error("read error alone");
  property p_err_hold;
    !$past(module_reset) && !$past(module_reset, 2) |->
      (($past(s) & ~$past(c) & ~$past(c, 2) & ~s & 16'h1111) == 16'h0000);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error lost");
  property p_mem_wr;
    mem_req && mem_wr |-> mem_wdata == ERR_BAD_EXEC && mem_addr != WORD_ZERO;
  endproperty
  a_mem_wr: assert property (p_mem_wr) else $error("bad error write");
endmodule : slot_handshake_properties
bind slot_handshake slot_handshake_properties u_chk (.sys_clk, .rst, .module_control_word, .command_control_word,
  .command_status_word, .mem_req, .mem_wr, .mem_addr, .mem_wdata, .module_reset);
`default_nettype wire

// *** dv/block_memory_model.sv ***
// controller memory holding command blocks
// assumes combinational reads, writes on the registered port
`timescale 1ns/1ps
`default_nettype none
module block_memory_model
  import slot_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sig_ok,
  input  wire logic        mem_req,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic [15:0]      mem_rdata,
  output int               n_wr,
  output logic [15:0]      wr_addr,
  output logic [15:0]      wr_data
);
  assign mem_rdata = sig_ok ? {SIGNATURE, 8'h01} : {~SIGNATURE, 8'hfe};
  initial n_wr = 0;
  always @(posedge sys_clk) if (mem_req && mem_wr) begin
    n_wr <= n_wr + 1;
    wr_addr <= mem_addr;
    wr_data <= mem_wdata;
  end
endmodule : block_memory_model
`default_nettype wire

// *** dv/slot_handshake_bench.sv ***
// self-checking bench for slot_handshake
// assumes block_memory_model on the memory port
`timescale 1ns/1ps
`default_nettype none
module slot_handshake_bench
  import slot_pkg::*;
;
  logic        sys_clk, rst, sig_ok, b, mre, mrq, mwr, sde;
  logic [3:0]  fail;
  logic [15:0] mcw, ccw, sw, rd, ma, md, wa, wd, acc;
  logic [15:0] ptr [4];
  logic [31:0] seed = 32'h8ce3_ae12;
  int          n_mismatch = 0, n_compared = 0, n_wr, n0, rises;
  slot_handshake dut_u (.sys_clk, .rst, .module_control_word(mcw), .command_control_word(ccw),
    .slot1_block_pointer(ptr[0]), .slot2_block_pointer(ptr[1]), .slot3_block_pointer(ptr[2]),
    .slot4_block_pointer(ptr[3]), .mem_rdata(rd), .exec_fail(fail), .command_status_word(sw),
    .mem_req(mrq), .mem_wr(mwr), .mem_addr(ma), .mem_wdata(md), .shared_data_enable(sde), .module_reset(mre));
  block_memory_model mem_u (.sys_clk, .sig_ok, .mem_req(mrq), .mem_wr(mwr), .mem_addr(ma), .mem_wdata(md),
    .mem_rdata(rd), .n_wr, .wr_addr(wa), .wr_data(wd));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic logic [15:0] at(input int s, input logic [3:0] g);
    at = 16'(g) << (4 * s);
  endfunction : at
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic set(input logic [15:0] cv, input logic [15:0] mv = 16'h0000);
    @(posedge sys_clk);
    ccw <= cv;
    mcw <= mv;
    @(negedge sys_clk);
  endtask : set
  task automatic wait_sw(input int i, input logic v);
    for (int k = 0; k < 40 && sw[i] !== v; k++) @(negedge sys_clk);
  endtask : wait_sw
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    rst = 1; mcw = 0; ccw = 0; fail = 0; sig_ok = 1; b = 0; acc = 0; rises = 0;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      ptr[i] = seed[15:0] | 16'h0010;
    end
    repeat (10) @(posedge sys_clk);
    rst <= 0;
    set(at(0, 4'b0110));
    wait_sw(2, 1);
    chk(sw, at(0, 4'b0100));
    repeat (20) @(negedge sys_clk);
    chk(sw, at(0, 4'b0100));
    set(0);
    wait_sw(2, 0);
    chk(sw, 0);
    set(16'h4444);
    for (int k = 0; k < 60; k++) begin
      @(negedge sys_clk);
      if (sw[2] && !b) rises++;
      b = sw[2];
      acc = acc | sw;
    end
    chk(acc, 16'h4444);
    chk(16'(rises > 1), 16'h0001);
    set(0);
    repeat (20) @(negedge sys_clk);
    chk(sw, 0);
    for (int e = 0; e < 3; e++) begin
      n0 = n_wr;
      fail <= (e == 0) ? 4'b0010 : 4'b0000;
      sig_ok <= (e != 1);
      if (e == 2) ptr[3] <= WORD_ZERO;
      set(at(e + 1, 4'b0110));
      wait_sw(4 * (e + 1), 1);
      set(0);
      repeat (5) @(negedge sys_clk);
      chk(sw & ~16'h4444, at(e + 1, e ? 4'b0011 : 4'b0001));
      chk(16'(n_wr - n0), e ? 16'h0000 : 16'h0001);
      if (e == 0) chk(wa, ptr[1]);
      if (e == 0) chk(wd, ERR_BAD_EXEC);
      set(at(e + 1, 4'b0001));
      wait_sw(4 * (e + 1), 0);
      chk(sw, 0);
      set(0);
    end
    sig_ok <= 1;
    set(at(0, 4'b0110));
    wait_sw(2, 1);
    set(at(0, 4'b1110));
    wait_sw(3, 1);
    chk(sw, at(0, 4'b1100));
    wait_sw(3, 0);
    chk(sw & 16'h000c, 0);
    set(0);
    repeat (30) @(negedge sys_clk);
    set(16'h8880, 16'h0041);
    repeat (4) @(negedge sys_clk);
    chk({14'h0, sde, mre}, 16'h0002);
    set(16'h8888, 16'h0001);
    repeat (4) @(negedge sys_clk);
    chk({14'h0, sde, mre}, 16'h0001);
    chk(sw, 0);
    set(0);
    repeat (4) @(negedge sys_clk);
    set(at(0, 4'b0110));
    wait_sw(2, 1);
    chk(sw, at(0, 4'b0100));
    wrap_up();
  end
endmodule : slot_handshake_bench
`default_nettype wire
